// >>> hdl/io_channel.sv
`timescale 1ns/1ns
module io_channel #(
  parameter bit HAS_CASCADE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] field,
  input wire logic field_wr,
  input wire pin_io_pkg::chan_in_t chan_in,
  input wire logic cascade_evt,
  input wire logic greg_wr,
  input wire logic [pin_io_pkg::CNT_W-1:0] greg_wdata,
  output logic [pin_io_pkg::CNT_W-1:0] greg,
  output pin_io_pkg::chan_out_t chan_out,
  output pin_io_pkg::io_mode_t mode,
  output logic match_pulse,
  output logic capture_pulse
);
  import pin_io_pkg::*;

  logic pin_prev_reg;
  logic prev_valid_reg;
  logic pin_level_reg;
  logic rise;
  logic fall;
  logic is_compare;

  assign mode = decode_mode(field, HAS_CASCADE);
  assign is_compare = mode inside {MODE_OC_LOW, MODE_OC_HIGH, MODE_OC_TOGGLE};
  // no edge is reported until one sample of the pin has been taken after reset
  assign rise = prev_valid_reg && !pin_prev_reg && chan_in.pin_in;
  assign fall = prev_valid_reg && pin_prev_reg && !chan_in.pin_in;
  assign match_pulse = is_compare && chan_in.count_step && (chan_in.count == greg);

  always_comb begin
    case (mode)
      MODE_IC_RISE: capture_pulse = rise;
      MODE_IC_FALL: capture_pulse = fall;
      MODE_IC_BOTH: capture_pulse = rise | fall;
      MODE_IC_CASCADE: capture_pulse = cascade_evt;
      default: capture_pulse = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_prev_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
    end else begin
      pin_prev_reg <= chan_in.pin_in;
      prev_valid_reg <= 1'b1;
    end
  end

  // a capture overrides a software write landing in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      greg <= GENERAL_REG_RST;
    end else if (capture_pulse) begin
      greg <= chan_in.count;
    end else if (greg_wr) begin
      greg <= greg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_level_reg <= 1'b0;
    end else if (field_wr && is_compare) begin
      pin_level_reg <= field[MODE_SEL_LEVEL];
    end else if (match_pulse) begin
      case (mode)
        MODE_OC_LOW: pin_level_reg <= 1'b0;
        MODE_OC_HIGH: pin_level_reg <= 1'b1;
        default: pin_level_reg <= ~pin_level_reg;
      endcase
    end
  end

  assign chan_out.pin_out = pin_level_reg;
  assign chan_out.pin_oe_n = !is_compare;
endmodule : io_channel

// >>> hdl/pin_io_pkg.sv
package pin_io_pkg;
  localparam int CNT_W = 16;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;

  // byte offsets of the register port
  localparam logic [7:0] CH4_IO_CONTROL_OFS = 8'h00;
  localparam logic [7:0] CH5_IO_CONTROL_OFS = 8'h04;
  localparam logic [7:0] CH0_IO_CONTROL_HIGH_OFS = 8'h08;
  localparam logic [7:0] CH4_GENERAL_REG_B_OFS = 8'h0c;
  localparam logic [7:0] CH5_GENERAL_REG_B_OFS = 8'h10;
  localparam logic [7:0] CH0_GENERAL_REG_A_OFS = 8'h14;
  localparam logic [7:0] EVENT_STATUS_OFS = 8'h18;
  localparam logic [7:0] PIN_STATUS_OFS = 8'h1c;
  localparam logic [7:0] MODE_STATUS_OFS = 8'h20;

  // field positions inside the control bytes and the status words
  localparam int B_FIELD_LSB = 4;
  localparam int A_FIELD_LSB = 0;
  localparam int MODE_SEL_CAPTURE = 3;
  localparam int MODE_SEL_LEVEL = 2;
  localparam int MODE_SEL_HI = 1;
  localparam int MODE_SEL_LO = 0;
  localparam int EVT_MATCH_LSB = 0;
  localparam int EVT_CAPTURE_LSB = 4;
  localparam int PIN_LEVEL_LSB = 0;
  localparam int PIN_OE_N_LSB = 4;

  localparam logic [7:0] IO_CONTROL_RST = 8'h00;
  localparam logic [CNT_W-1:0] GENERAL_REG_RST = 16'hffff;

  typedef enum logic [7:0] {
    MODE_OFF = 8'h01,
    MODE_OC_LOW = 8'h02,
    MODE_OC_HIGH = 8'h04,
    MODE_OC_TOGGLE = 8'h08,
    MODE_IC_RISE = 8'h10,
    MODE_IC_FALL = 8'h20,
    MODE_IC_BOTH = 8'h40,
    MODE_IC_CASCADE = 8'h80
  } io_mode_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic count_step;
    logic pin_in;
  } chan_in_t;

  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } chan_out_t;

  function automatic io_mode_t decode_mode(input logic [3:0] f, input logic has_cascade);
    io_mode_t m;
    m = MODE_OFF;
    if (!f[MODE_SEL_CAPTURE]) begin
      case (f[MODE_SEL_HI:MODE_SEL_LO])
        2'b01: m = MODE_OC_LOW;
        2'b10: m = MODE_OC_HIGH;
        2'b11: m = MODE_OC_TOGGLE;
        default: m = MODE_OFF;
      endcase
    end else if (f[MODE_SEL_LEVEL] && has_cascade) begin
      m = MODE_IC_CASCADE;
    end else if (f[MODE_SEL_HI]) begin
      m = MODE_IC_BOTH;
    end else if (f[MODE_SEL_LO]) begin
      m = MODE_IC_FALL;
    end else begin
      m = MODE_IC_RISE;
    end
    return m;
  endfunction : decode_mode
endpackage : pin_io_pkg

// >>> hdl/timer_pin_io_mode_decode.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
module timer_pin_io_mode_decode #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [pin_io_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pin_io_pkg::DATA_W-1:0] rdata,
  // index 0: channel 4 B, 1: channel 5 B, 2: channel 0 A
  input wire pin_io_pkg::chan_in_t [pin_io_pkg::NUM_CH-1:0] chan_in,
  input wire logic ch3_c_event,
  input wire logic ch1_count_step,
  output pin_io_pkg::chan_out_t [pin_io_pkg::NUM_CH-1:0] chan_out,
  output logic [pin_io_pkg::NUM_CH-1:0] match_evt,
  output logic [pin_io_pkg::NUM_CH-1:0] capture_evt
);
  import pin_io_pkg::*;

  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must cover offsets up to 0x20 and stay within 32 bits");
  end

  logic [7:0] ctrl_reg [NUM_CH];
  logic [NUM_CH-1:0] ctrl_wr;
  logic [NUM_CH-1:0] greg_wr;
  logic [CNT_W-1:0] greg [NUM_CH];
  io_mode_t mode [NUM_CH];
  logic [NUM_CH-1:0] cascade_evt;
  logic [NUM_CH-1:0] match_flag_reg;
  logic [NUM_CH-1:0] capture_flag_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [7:0] ofs;
  logic status_wr;

  function automatic int field_lsb(input int ch);
    return (ch == 2) ? A_FIELD_LSB : B_FIELD_LSB;
  endfunction : field_lsb

  function automatic logic [7:0] ctrl_ofs(input int ch);
    logic [7:0] o;
    o = CH4_IO_CONTROL_OFS;
    if (ch == 1) begin
      o = CH5_IO_CONTROL_OFS;
    end else if (ch == 2) begin
      o = CH0_IO_CONTROL_HIGH_OFS;
    end
    return o;
  endfunction : ctrl_ofs

  function automatic logic [7:0] greg_ofs(input int ch);
    logic [7:0] o;
    o = CH4_GENERAL_REG_B_OFS;
    if (ch == 1) begin
      o = CH5_GENERAL_REG_B_OFS;
    end else if (ch == 2) begin
      o = CH0_GENERAL_REG_A_OFS;
    end
    return o;
  endfunction : greg_ofs

  // addresses above the byte range fold to an unmapped offset
  assign ofs = (addr > ADDR_W'(8'hff)) ? 8'hff : 8'(addr);
  assign status_wr = wr && (ofs == EVENT_STATUS_OFS);

  // cascade sources per channel; channel 5 has none
  assign cascade_evt[0] = ch3_c_event;
  assign cascade_evt[1] = 1'b0;
  assign cascade_evt[2] = ch1_count_step;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign ctrl_wr[i] = wr && (ofs == ctrl_ofs(i));
    assign greg_wr[i] = wr && (ofs == greg_ofs(i));

    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        ctrl_reg[i] <= IO_CONTROL_RST;
      end else if (ctrl_wr[i]) begin
        ctrl_reg[i] <= wdata[7:0];
      end
    end

    // the new field and its write strobe reach the channel together, so the
    // initial level is applied in the same cycle the mode takes effect
    io_channel #(
      .HAS_CASCADE(i != 1)
    ) u_chan (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .field(ctrl_wr[i] ? wdata[field_lsb(i) +: 4] : ctrl_reg[i][field_lsb(i) +: 4]),
      .field_wr(ctrl_wr[i]),
      .chan_in(chan_in[i]),
      .cascade_evt(cascade_evt[i]),
      .greg_wr(greg_wr[i]),
      .greg_wdata(wdata[CNT_W-1:0]),
      .greg(greg[i]),
      .chan_out(chan_out[i]),
      .mode(mode[i]),
      .match_pulse(match_evt[i]),
      .capture_pulse(capture_evt[i])
    );
  end

  // sticky event flags, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      match_flag_reg <= '0;
    end else begin
      match_flag_reg <= (match_flag_reg & ~({NUM_CH{status_wr}} &
                         wdata[EVT_MATCH_LSB +: NUM_CH])) | match_evt;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_flag_reg <= '0;
    end else begin
      capture_flag_reg <= (capture_flag_reg & ~({NUM_CH{status_wr}} &
                           wdata[EVT_CAPTURE_LSB +: NUM_CH])) | capture_evt;
    end
  end

  always_comb begin
    rdata_next = '0;
    if (!rd) begin
      rdata_next = '0;
    end else if (ofs == CH4_IO_CONTROL_OFS) begin
      rdata_next[7:0] = ctrl_reg[0];
    end else if (ofs == CH5_IO_CONTROL_OFS) begin
      rdata_next[7:0] = ctrl_reg[1];
    end else if (ofs == CH0_IO_CONTROL_HIGH_OFS) begin
      rdata_next[7:0] = ctrl_reg[2];
    end else if (ofs == CH4_GENERAL_REG_B_OFS) begin
      rdata_next[CNT_W-1:0] = greg[0];
    end else if (ofs == CH5_GENERAL_REG_B_OFS) begin
      rdata_next[CNT_W-1:0] = greg[1];
    end else if (ofs == CH0_GENERAL_REG_A_OFS) begin
      rdata_next[CNT_W-1:0] = greg[2];
    end else if (ofs == EVENT_STATUS_OFS) begin
      rdata_next[EVT_MATCH_LSB +: NUM_CH] = match_flag_reg;
      rdata_next[EVT_CAPTURE_LSB +: NUM_CH] = capture_flag_reg;
    end else if (ofs == PIN_STATUS_OFS) begin
      for (int k = 0; k < NUM_CH; k++) begin
        rdata_next[PIN_LEVEL_LSB + k] = chan_out[k].pin_out;
        rdata_next[PIN_OE_N_LSB + k] = chan_out[k].pin_oe_n;
      end
    end else if (ofs == MODE_STATUS_OFS) begin
      for (int k = 0; k < NUM_CH; k++) begin
        rdata_next[8*k +: 8] = mode[k];
      end
    end
  end

  // read data lives for exactly the one cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
endmodule : timer_pin_io_mode_decode

// >>> verif/pin_partner.sv
`timescale 1ns/1ns
module pin_partner (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [4:0] stim,
  output pin_io_pkg::chan_in_t [pin_io_pkg::NUM_CH-1:0] chan_in,
  output logic ch3_c_event,
  output logic ch1_count_step
);
  import pin_io_pkg::*;
  logic [CNT_W-1:0] count_reg;
  logic [4:0] stim_reg;
  logic phase_reg;
  // counter steps every other cycle so the step qualifier is also seen low,
  // and a count value that equals the register stands for two cycles
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      stim_reg <= '0;
      phase_reg <= 1'b0;
    end else begin
      if (phase_reg) begin
        count_reg <= count_reg + 16'h0001;
      end
      phase_reg <= ~phase_reg;
      stim_reg <= stim;
    end
  end
  // events are one pulse however long the request is held
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ch3_c_event <= 1'b0;
      ch1_count_step <= 1'b0;
    end else begin
      ch3_c_event <= stim[3] & ~stim_reg[3];
      ch1_count_step <= stim[4] & ~stim_reg[4];
    end
  end
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      chan_in[k] = '{count: count_reg, count_step: !phase_reg, pin_in: stim_reg[k]};
    end
  end
endmodule : pin_partner

// >>> verif/tb_timer_pin_io_mode_decode.sv
`timescale 1ns/1ns
module tb_timer_pin_io_mode_decode;
  import pin_io_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] stim = 5'h00;
  logic [DATA_W-1:0] rdata;
  chan_in_t [NUM_CH-1:0] chan_in;
  chan_out_t [NUM_CH-1:0] chan_out;
  logic ch3_c_event;
  logic ch1_count_step;
  logic [NUM_CH-1:0] match_evt;
  logic [NUM_CH-1:0] capture_evt;
  logic [31:0] seed = 32'h0000_fa1b;
  int miscompares = 0;
  int tests_run = 0;
  always #4 ref_clk = ~ref_clk;
  timer_pin_io_mode_decode uut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .chan_in(chan_in), .ch3_c_event(ch3_c_event),
    .ch1_count_step(ch1_count_step), .chan_out(chan_out), .match_evt(match_evt),
    .capture_evt(capture_evt));
  pin_partner far (.ref_clk(ref_clk), .rstn(rstn), .stim(stim), .chan_in(chan_in),
    .ch3_c_event(ch3_c_event), .ch1_count_step(ch1_count_step));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift
  // toggle starts from the initial level
  function automatic logic exp_pin(input logic [3:0] f);
    return (f[1:0] == 2'b11) ? !f[2] : f[1];
  endfunction : exp_pin
  // one-hot mode code that a field must select on channel k
  function automatic logic [7:0] exp_mode(input logic [3:0] f, input int k);
    logic [7:0] m;
    m = MODE_OFF;
    if (!f[3]) begin
      if (f[1:0] != 2'b00) m = 8'h01 << f[1:0];
    end else if (f[2] && k != 1) begin
      m = MODE_IC_CASCADE;
    end else begin
      m = f[1] ? MODE_IC_BOTH : (f[0] ? MODE_IC_FALL : MODE_IC_RISE);
    end
    return m;
  endfunction : exp_mode
  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
    #1;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd
  task automatic step(input logic [4:0] v);
    @(posedge ref_clk);
    stim <= v;
    @(posedge ref_clk);
    #1;
  endtask : step
  task automatic chk_cap(input int k, input logic e);
    logic [CNT_W-1:0] c;
    logic [31:0] d;
    c = chan_in[0].count;
    cmp("capture_evt", 32'(e), 32'(capture_evt[k]));
    if (e) begin
      reg_rd(CH4_GENERAL_REG_B_OFS + 8'(4 * k), d);
      cmp("captured count", 32'(c), d);
      reg_rd(EVENT_STATUS_OFS, d);
      cmp("capture flag", 32'h0000_0001, 32'(d[EVT_CAPTURE_LSB + k]));
      reg_wr(EVENT_STATUS_OFS, 32'h0000_0001 << (EVT_CAPTURE_LSB + k));
      reg_rd(EVENT_STATUS_OFS, d);
      cmp("capture flag cleared", 32'h0000_0000, 32'(d[EVT_CAPTURE_LSB + k]));
    end
  endtask : chk_cap
  initial begin
    logic [31:0] d;
    logic [3:0] f;
    logic [15:0] g;
    logic hit;
    logic casc;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int k = 0; k < NUM_CH; k++) begin
      reg_rd(CH4_IO_CONTROL_OFS + 8'(4 * k), d);
      cmp("control reset", 32'(IO_CONTROL_RST), d);
      reg_rd(CH4_GENERAL_REG_B_OFS + 8'(4 * k), d);
      cmp("general reset", 32'(GENERAL_REG_RST), d);
    end
    reg_rd(8'h40, d);
    cmp("unmapped read", 32'h0000_0000, d);
    for (int k = 0; k < NUM_CH; k++) begin
      for (int i = 0; i < 16; i++) begin
        f = 4'(i);
        reg_wr(CH4_IO_CONTROL_OFS + 8'(4 * k), (k == 2) ? 32'(f) : 32'(f) << 4);
        reg_rd(MODE_STATUS_OFS, d);
        cmp("mode status", 32'(exp_mode(f, k)), 32'(d[8 * k +: 8]));
        if (!f[3]) begin
          cmp("oe_n", 32'(f[1:0] == 2'b00), 32'(chan_out[k].pin_oe_n));
          if (f[1:0] != 2'b00) begin
            cmp("initial level", 32'(f[2]), 32'(chan_out[k].pin_out));
            seed = xorshift(seed);
            g = chan_in[0].count + 16'h0004 + 16'(seed[2:0]);
            reg_wr(CH4_GENERAL_REG_B_OFS + 8'(4 * k), 32'(g));
            hit = 1'b0;
            for (int w = 0; w < 32 && !hit; w++) begin
              @(posedge ref_clk);
              #1;
              hit = (match_evt[k] === 1'b1);
            end
            if (!hit) begin
              miscompares++;
              end_sim();
            end
            cmp("match count", 32'(g), 32'(chan_in[0].count));
            @(posedge ref_clk);
            #1;
            cmp("pin after match", 32'(exp_pin(f)), 32'(chan_out[k].pin_out));
          end
        end else begin
          casc = (k != 1) && f[2];
          step(5'(1 << k));
          chk_cap(k, !casc && (f[1] || !f[0]));
          step(5'h00);
          chk_cap(k, !casc && (f[1] || f[0]));
          step((k == 2) ? 5'h10 : 5'h08);
          chk_cap(k, casc);
          step(5'h00);
        end
      end
    end
    end_sim();
  end
endmodule : tb_timer_pin_io_mode_decode

// >>> verif/timer_pin_io_mode_decode_properties.sv
`timescale 1ns/1ns
module timer_pin_io_mode_decode_properties (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wr,
  input wire pin_io_pkg::chan_in_t [pin_io_pkg::NUM_CH-1:0] chan_in,
  input wire logic ch3_c_event,
  input wire logic ch1_count_step,
  input wire pin_io_pkg::chan_out_t [pin_io_pkg::NUM_CH-1:0] chan_out,
  input wire logic [pin_io_pkg::NUM_CH-1:0] match_evt,
  input wire logic [pin_io_pkg::NUM_CH-1:0] capture_evt
);
  import pin_io_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    property p_step; match_evt[k] |-> chan_in[k].count_step; endproperty
    a_step: assert property (p_step) else $error("match off step");
    property p_drv; match_evt[k] |-> !chan_out[k].pin_oe_n; endproperty
    a_drv: assert property (p_drv) else $error("match on idle pin");
    property p_flt; capture_evt[k] |-> chan_out[k].pin_oe_n; endproperty
    a_flt: assert property (p_flt) else $error("capture on driven pin");
    property p_excl; !(match_evt[k] && capture_evt[k]); endproperty
    a_excl: assert property (p_excl) else $error("match and capture");
    // the pin only moves for a match or a software write
    property p_cause; $changed(chan_out[k].pin_out) |-> $past(match_evt[k] || wr); endproperty
    a_cause: assert property (p_cause) else $error("pin moved alone");
  end
  property p_src4; capture_evt[0] |-> $changed(chan_in[0].pin_in) || ch3_c_event; endproperty
  a_src4: assert property (p_src4) else $error("bad source 0");
  property p_src5; capture_evt[1] |-> $changed(chan_in[1].pin_in); endproperty
  a_src5: assert property (p_src5) else $error("bad source 1");
  property p_src0; capture_evt[2] |-> $changed(chan_in[2].pin_in) || ch1_count_step; endproperty
  a_src0: assert property (p_src0) else $error("bad source 2");
  c_match: cover property (match_evt[0]);
  c_casc: cover property (capture_evt[0] && ch3_c_event);
  c_step: cover property (capture_evt[2] && ch1_count_step);
endmodule : timer_pin_io_mode_decode_properties
bind timer_pin_io_mode_decode timer_pin_io_mode_decode_properties u_props (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .wr(wr),
  .chan_in(chan_in),
  .ch3_c_event(ch3_c_event),
  .ch1_count_step(ch1_count_step),
  .chan_out(chan_out),
  .match_evt(match_evt),
  .capture_evt(capture_evt)
);
